//--- dds_core.sv
// Phase accumulator core: tuning buffer, accumulator, lookup and sample FIFO
// How it works
// - Each sample step adds the buffered tuning word into the phase accumulator.
// - The present accumulator value addresses the waveform memory for that step.
// - Tuning word reaches the adder through a local phase register buffer.
// - Output depends only on clock, tuning value, memory contents and converter ready.
// - Fixed clock; frequency changes through the phase increment and the rate the converter takes samples.
// - One full cycle spans all 131072 memory locations.
// - A large increment skips samples, giving higher output frequency.
// - A small increment repeats samples, giving lower output frequency.
// - Memory is user writable so custom waveforms replay.
// - Each sample goes out as a binary word to the converter.
`timescale 1ns/10ps
`default_nettype none
module dds_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic [dds_pkg::TUNE_W-1:0] freq_word,
   input wire logic freq_load,
   input wire logic wave_wr_en,
   input wire logic [dds_pkg::ADDR_W-1:0] wave_wr_addr,
   input wire logic [dds_pkg::SAMPLE_W-1:0] wave_wr_data,
   output logic [dds_pkg::SAMPLE_W-1:0] dac_data,
   output logic dac_valid,
   input wire logic dac_ready
);
   logic [dds_pkg::TUNE_W-1:0] freq_reg, freq_next;
   logic [dds_pkg::TUNE_W-1:0] phase_inc_reg, phase_inc_next;
   logic [dds_pkg::TUNE_W-1:0] acc_reg, acc_next;
   logic [dds_pkg::ADDR_W-1:0] rd_addr;
   logic [dds_pkg::SAMPLE_W-1:0] mem_data;
   logic rd_valid_reg, rd_valid_next;
   logic fifo_in_ready;
   logic step;
   logic [dds_pkg::SAMPLE_W-1:0] fifo_out_data;
   logic fifo_out_valid;

   ////////////////////////////////////////////////////////////
   // Stall the accumulator when the FIFO cannot take the next sample,
   // so no phase step is lost; the converter side sets the true rate
   assign step = fifo_in_ready;

   // Frequency register
   always_comb begin
      freq_next = freq_reg;
      if (freq_load) begin
         freq_next = freq_word;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         freq_reg <= dds_pkg::TUNE_RESET;
      end else begin
         freq_reg <= freq_next;
      end
   end

   ////////////////////////////////////////////////////////////
   // Buffer is refreshed once per step, so a word change lands on a step edge
   always_comb begin
      phase_inc_next = phase_inc_reg;
      if (step) begin
         phase_inc_next = freq_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_inc_reg <= dds_pkg::TUNE_RESET;
      end else begin
         phase_inc_reg <= phase_inc_next;
      end
   end

   ////////////////////////////////////////////////////////////
   // Phase accumulator
   always_comb begin
      acc_next = acc_reg;
      if (step) begin
         acc_next = acc_reg + phase_inc_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         acc_reg <= dds_pkg::PHASE_RESET;
      end else begin
         acc_reg <= acc_next;
      end
   end

   ////////////////////////////////////////////////////////////
   // Memory read data stands one cycle after its step
   always_comb begin
      rd_valid_next = step;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= rd_valid_next;
      end
   end

   ////////////////////////////////////////////////////////////
   assign rd_addr = acc_reg[dds_pkg::TUNE_W-1:dds_pkg::ADDR_LSB];

   dds_wave_mem #(
      .DW(dds_pkg::SAMPLE_W),
      .AW(dds_pkg::ADDR_W),
      .DEPTH(dds_pkg::MEM_DEPTH)
   ) u_mem (
      .clk(clk),
      .rd_en(step),
      .rd_addr(rd_addr),
      .rd_data(mem_data),
      .wr_en(wave_wr_en),
      .wr_addr(wave_wr_addr),
      .wr_data(wave_wr_data)
   );

   ////////////////////////////////////////////////////////////
   // FIFO keeps no headroom: a read launched while ready may arrive at a full
   // FIFO, since ready drops only when all slots are counted
   logic [dds_pkg::SAMPLE_W-1:0] hold_reg, hold_next;
   logic hold_vld_reg, hold_vld_next;
   logic push_valid;
   logic [dds_pkg::SAMPLE_W-1:0] push_data;
   logic fifo_out_ready;
   logic [dds_pkg::SAMPLE_W-1:0] out_data_reg, out_data_next;
   logic out_vld_reg, out_vld_next;

   // A sample read in the last ready cycle may meet a full FIFO; park it
   assign push_valid = hold_vld_reg || rd_valid_reg;
   assign push_data = hold_vld_reg ? hold_reg : mem_data;

   always_comb begin
      hold_next = hold_reg;
      hold_vld_next = hold_vld_reg;
      if (hold_vld_reg) begin
         if (fifo_in_ready) begin
            hold_vld_next = rd_valid_reg;
            hold_next = mem_data;
         end
      end else if (rd_valid_reg && !fifo_in_ready) begin
         hold_vld_next = 1'b1;
         hold_next = mem_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hold_reg <= '0;
         hold_vld_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
         hold_vld_reg <= hold_vld_next;
      end
   end

   dds_fifo #(
      .WIDTH(dds_pkg::FIFO_W),
      .DEPTH(dds_pkg::FIFO_DEPTH),
      .AW(dds_pkg::FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(push_data),
      .in_valid(push_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready)
   );

   ////////////////////////////////////////////////////////////
   // Output stage: the converter sees a registered word, not the FIFO's read mux
   assign fifo_out_ready = !out_vld_reg || dac_ready;

   always_comb begin
      out_data_next = out_data_reg;
      out_vld_next = out_vld_reg;
      if (fifo_out_ready) begin
         out_vld_next = fifo_out_valid;
         if (fifo_out_valid) begin
            out_data_next = fifo_out_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out_data_reg <= '0;
         out_vld_reg <= 1'b0;
      end else begin
         out_data_reg <= out_data_next;
         out_vld_reg <= out_vld_next;
      end
   end

   assign dac_data = out_data_reg;
   assign dac_valid = out_vld_reg;
endmodule
`default_nettype wire

//--- dds_core_props.sv
// Port assertions for the synthesis core
`timescale 1ns/10ps
`default_nettype none
module dds_core_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic freq_load,
   input wire logic wave_wr_en,
   input wire logic [dds_pkg::ADDR_W-1:0] wave_wr_addr,
   input wire logic [dds_pkg::SAMPLE_W-1:0] wave_wr_data,
   input wire logic [dds_pkg::SAMPLE_W-1:0] dac_data,
   input wire logic dac_valid,
   input wire logic dac_ready
);
   logic quiet_reg, quiet_next;
   logic [13:0] mem0_reg, mem0_next;
   // Quiet until the first load or write after reset, so only address 0 is read
   always_comb begin
      quiet_next = rst | (quiet_reg & !freq_load & !wave_wr_en);
      mem0_next = (wave_wr_en && wave_wr_addr == 17'h0) ? wave_wr_data : mem0_reg;
   end
   always_ff @(posedge clk) begin
      quiet_reg <= quiet_next;
      mem0_reg <= mem0_next;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence popped;
      dac_valid && dac_ready;
   endsequence
   ////////////////////
   rst_clear_a: assert property (disable iff (1'b0) rst |=> !dac_valid)
      else $error("valid during reset");
   hold_valid_a: assert property (dac_valid && !dac_ready |=> dac_valid)
      else $error("valid dropped");
   hold_data_a: assert property (dac_valid && !dac_ready |=> $stable(dac_data))
      else $error("sample changed");
   first_sample_a: assert property ($fell(rst) |-> ##[0:3] dac_valid)
      else $error("no first sample");
   steady_flow_a: assert property (popped ##1 dac_ready |-> dac_valid)
      else $error("stream gap");
   zero_tune_a: assert property (quiet_reg && dac_valid |-> dac_data == mem0_reg)
      else $error("zero tune sample");
   valid_late_a: assert property ($rose(dac_valid) |-> !$past(rst))
      else $error("valid too early");
   stall_keep_a: assert property ((dac_valid && !dac_ready) [*8] |=> dac_valid && $stable(dac_data))
      else $error("sample lost");
endmodule
bind dds_core dds_core_props u_props (.clk(clk), .rst(rst), .freq_load(freq_load),
   .wave_wr_en(wave_wr_en), .wave_wr_addr(wave_wr_addr), .wave_wr_data(wave_wr_data),
   .dac_data(dac_data), .dac_valid(dac_valid), .dac_ready(dac_ready));
`default_nettype wire

//--- dds_dac_model.sv
// Converter model; slow mode stalls 41 cycles, then is ready every third cycle
`timescale 1ns/10ps
`default_nettype none
module dds_dac_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic [13:0] dac_data,
   input wire logic dac_valid,
   output logic dac_ready
);
   logic [13:0] got[$];
   int cyc = 0;
   always @(negedge clk) begin
      cyc = slow ? cyc + 1 : 0;
      dac_ready <= !slow || (cyc > 40 && cyc % 3 == 0);
   end
   always @(posedge clk) begin
      if (dac_valid && dac_ready) got.push_back(dac_data);
   end
endmodule
`default_nettype wire

//--- dds_fifo.sv
// Sample FIFO between the lookup and the converter port
`timescale 1ns/10ps
`default_nettype none
module dds_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [AW:0] count_reg, count_next;
   logic do_wr, do_rd;

   ////////////////////////////////////////////////////////////
   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   assign out_data = mem[rptr_reg];

   always_comb begin
      wptr_next = wptr_reg;
      rptr_next = rptr_reg;
      count_next = count_reg;
      if (do_wr) begin
         wptr_next = wptr_reg + 1'b1;
      end
      if (do_rd) begin
         rptr_next = rptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
         count_next = count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         count_reg <= count_next;
      end
   end

   // Storage is not reset; entries are only read once counted in
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wptr_reg] <= in_data;
      end
   end
endmodule
`default_nettype wire

//--- dds_pkg.sv
// Shared constants for the phase accumulator synthesis core
package dds_pkg;
   localparam int TUNE_W = 32;
   localparam int ADDR_W = 17;
   localparam int SAMPLE_W = 14;
   localparam int MEM_DEPTH = 131072;
   localparam int FIFO_W = 14;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam logic [31:0] TUNE_RESET = 32'h0000_0000;
   localparam logic [31:0] PHASE_RESET = 32'h0000_0000;
   localparam int ADDR_LSB = TUNE_W - ADDR_W;
   localparam int CLK_HZ = 40000000;
endpackage

//--- dds_wave_mem.sv
// Waveform sample memory with registered read and user write port
`timescale 1ns/10ps
`default_nettype none
module dds_wave_mem #(
   parameter int DW = 14,
   parameter int AW = 17,
   parameter int DEPTH = 131072
) (
   input wire logic clk,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data
);
   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

//--- test_dds_core.sv
// Self-checking bench for the synthesis core
`timescale 1ns/10ps
`default_nettype none
module test_dds_core;
   logic clk = 0, rst = 1, freq_load = 0, wave_wr_en = 0, slow = 0;
   logic [31:0] freq_word = 32'h0;
   logic [16:0] wave_wr_addr = 17'h0;
   logic [13:0] wave_wr_data = 14'h0, dac_data;
   logic dac_valid, dac_ready;
   int n_errors = 0, n_tests = 0;
   dds_core u_dut (.clk(clk), .rst(rst), .freq_word(freq_word), .freq_load(freq_load),
      .wave_wr_en(wave_wr_en), .wave_wr_addr(wave_wr_addr), .wave_wr_data(wave_wr_data),
      .dac_data(dac_data), .dac_valid(dac_valid), .dac_ready(dac_ready));
   dds_dac_model u_dac (.clk(clk), .slow(slow), .dac_data(dac_data), .dac_valid(dac_valid), .dac_ready(dac_ready));
   initial forever #12.5 clk = ~clk;
   function automatic logic [16:0] adr(int k, logic [31:0] t);
      logic [31:0] s;
      s = t * 32'(k);
      return s[31:15];
   endfunction
   function automatic logic [13:0] wv(logic [16:0] a);
      return a[13:0] ^ {a[16:14], 11'h0};
   endfunction
   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(logic [13:0] exp, logic [13:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch dac_data expected %h seen %h", exp, got);
      end
   endtask
   ////////////////////
   // Memory is filled under reset, so the leading zero samples mark the old tuning
   task automatic run(logic [31:0] t, int n, logic s);
      int k;
      int i;
      rst = 1;
      for (k = 0; k <= n + 80; k++) begin
         wave_wr_en = 1;
         wave_wr_addr = adr(k, t);
         wave_wr_data = wv(adr(k, t));
         @(negedge clk);
      end
      wave_wr_en = 0;
      u_dac.got.delete();
      rst = 0;
      // Slow mode starts here so its long stall fills the FIFO after reset
      slow = s;
      repeat (4) @(negedge clk);
      freq_word = t;
      freq_load = 1;
      @(negedge clk);
      freq_load = 0;
      for (i = 0; i < 5000 && u_dac.got.size() < n + 40; i++) @(negedge clk);
      n_tests++;
      if (u_dac.got.size() < n + 40) begin
         n_errors++;
         $display("mismatch sample_count expected %0d seen %0d", n + 40, u_dac.got.size());
      end
      i = 0;
      while (i < u_dac.got.size() && u_dac.got[i] === 14'h0) i++;
      k = 1;
      while (adr(k, t) == 17'h0) k++;
      // Load lands four cycles after release; buffer and adder add two more address-0 reads
      n_tests++;
      if (i != 6 + k) begin
         n_errors++;
         $display("mismatch lead_zeros expected %0d seen %0d", 6 + k, i);
      end
      repeat (n) begin
         check(wv(adr(k, t)), u_dac.got[i]);
         i++;
         k++;
      end
   endtask
   task automatic s_skip();
      run(32'h0004_0000, 12, 1'b0);
   endtask
   task automatic s_repeat();
      run(32'h0000_4000, 12, 1'b1);
   endtask
   task automatic s_wrap();
      run(32'hC000_0000, 3, 1'b0);
   endtask
   initial begin
      #500000;
      n_errors++;
      test_done();
   end
   initial begin
      repeat (4) @(negedge clk);
      s_skip();
      s_repeat();
      s_wrap();
      test_done();
   end
endmodule
`default_nettype wire
